// file: rfis_lfsr.sv
// Seven stage random interval generator
`timescale 1ns/10ps
`default_nettype none

module rfis_lfsr (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       sys_rst_i,
	// Control
	input  wire logic       load_i,
	input  wire logic [6:0] seed_i,
	input  wire logic       step_i,
	output logic      [6:0] value_o
);
	import rfis_pkg::*;

	typedef struct packed {
		logic [6:0] sr;
	} rfis_lfsr_s;

	rfis_lfsr_s r;
	rfis_lfsr_s next_r;

	always_comb begin
		next_r = r;
		if (load_i) begin
			next_r.sr = seed_i;
		// [RULE24] Galois feedback form
		end else if (step_i) begin
			next_r.sr = {1'b0, r.sr[6:1]} ^ (r.sr[0] ? LFSR_TAPS : 7'h00);
		end
	end

	// [RULE15] power-up preset value
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			r.sr <= LFSR_RESET;
		end else begin
			r <= next_r;
		end
	end

	assign value_o = r.sr;

	// [RULE14] never falls to zero
	a_lfsr_nonzero: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(step_i && !load_i && value_o != 7'h00) |=> value_o != 7'h00) // [RULE14]
		else $error("random generator fell to zero");

endmodule : rfis_lfsr

`default_nettype wire

// file: rfis_pkg.sv
// Constants and types shared by the frame interval sequencer
`default_nettype none

package rfis_pkg;

	////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int MFO_PERIOD_NS = 8000;
	localparam int MFO_DIV       = 125;
	// One interval step; well above 4096 cycles, so the top overrides it
	localparam int TICK_CYCLES   = MFO_PERIOD_NS * MFO_DIV / CLK_PERIOD_NS;
	// Bit time of the line coder is fixed here; no parameter overrides it
	localparam int BIT_TIME_NS   = 50000;
	localparam int BIT_CYCLES    = BIT_TIME_NS / CLK_PERIOD_NS;
	localparam logic [11:0] BIT_LAST = 12'(BIT_CYCLES - 1);
	localparam logic [8:0]  EOM_BITS = 9'h002;
	localparam logic [6:0]  INIT_SCALE = 7'h28;

	////////////////////////////////////////////////////////////////////////
	// Random generator
	localparam logic [6:0] LFSR_RESET = 7'h40;
	localparam logic [6:0] LFSR_TAPS  = 7'h60;

	////////////////////////////////////////////////////////////////////////
	// Register offsets (byte addresses)
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_FLEN = 8'h04;
	localparam logic [7:0] OFS_REP  = 8'h08;
	localparam logic [7:0] OFS_BASE = 8'h0C;
	localparam logic [7:0] OFS_SEED = 8'h10;
	localparam logic [7:0] OFS_STEP = 8'h14;
	localparam logic [2:0] OFS_BUF_PAGE = 3'h1;

	// Control register fields
	localparam int CTRL_SEND   = 0;
	localparam int CTRL_IRQEN  = 1;
	localparam int CTRL_EOM    = 2;
	localparam int CTRL_ISCALE = 3;
	localparam int CTRL_KEEP   = 4;
	localparam int CTRL_DONE   = 5;

	// Reset values
	localparam logic [7:0] RST_FLEN = 8'h07;
	localparam logic [3:0] RST_REP  = 4'h0;
	localparam logic [7:0] RST_BASE = 8'h00;
	localparam logic [6:0] RST_SEED = 7'h00;
	localparam logic [5:0] RST_STEP = 6'h00;

	////////////////////////////////////////////////////////////////////////
	// Sequencer states
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_DELAY  = 3'b001,
		ST_FRAME  = 3'b010,
		ST_MARKER = 3'b011,
		ST_END    = 3'b100
	} rfis_state_e;

endpackage : rfis_pkg

`default_nettype wire

// file: rfis_rf_model.sv
// Output stage model: captures frame bits, marker time and gap lengths
`timescale 1ns/10ps
`default_nettype none

module rfis_rf_model (
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         sys_rst_i,
	// Stage inputs
	input  wire logic         start_i,
	input  wire logic         pa_on_i,
	input  wire logic         tx_bit_i,
	input  wire logic         end_marker_i,
	input  wire logic         irq_i,
	// Observations of the last transmission
	output logic      [4:0]   frames_o,
	output logic      [255:0] bits_o,
	output logic      [8:0]   nbits_o,
	output logic      [15:0]  on_cyc_o,
	output logic      [15:0]  mark_cyc_o,
	output logic      [15:0]  errs_o,
	output logic      [3:0]   irqs_o,
	output logic      [15:0]  gaps_o [16]
);
	logic        prev_pa;
	logic [15:0] gap;

	////////////////////////////////////////////////////////////////////////
	// Bits are taken mid bit, away from the edges where the coder switches
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			prev_pa <= 1'b0;
			gap <= 16'h0000;
			frames_o <= 5'h00;
			nbits_o <= 9'h000;
			on_cyc_o <= 16'h0000;
			mark_cyc_o <= 16'h0000;
			errs_o <= 16'h0000;
			irqs_o <= 4'h0;
		end else begin
			prev_pa <= pa_on_i;
			if (irq_i)
				irqs_o <= irqs_o + 4'h1;
			if (!pa_on_i && (tx_bit_i || end_marker_i))
				errs_o <= errs_o + 16'h0001;
			// marker is carrier at level one
			if (end_marker_i && !tx_bit_i)
				errs_o <= errs_o + 16'h0001;
			if (start_i) begin
				frames_o <= 5'h00;
				gap <= 16'h0000;
				irqs_o <= 4'h0;
				errs_o <= 16'h0000;
			end else if (!pa_on_i) begin
				gap <= gap + 16'h0001;
			end else if (!prev_pa) begin
				gaps_o[frames_o[3:0]] <= gap;
				frames_o <= frames_o + 5'h01;
				gap <= 16'h0000;
				on_cyc_o <= 16'h0001;
				nbits_o <= 9'h000;
				mark_cyc_o <= 16'h0000;
			end else begin
				on_cyc_o <= on_cyc_o + 16'h0001;
				if (end_marker_i) begin
					mark_cyc_o <= mark_cyc_o + 16'h0001;
				end else if (on_cyc_o % 2500 == 1250) begin
					bits_o[nbits_o[7:0]] <= tx_bit_i;
					nbits_o <= nbits_o + 9'h001;
				end
			end
		end
	end
endmodule : rfis_rf_model

`default_nettype wire

// file: rfis_sequencer.sv
// Frame interval sequencer: buffer, timers, frame repeat and end marker
//
// What the document requires of this block and its software
// [RULE1] Sends frame length field plus one bits
// [RULE2] Interrupt on frame done when enabled
// [RULE3] End marker adds two carrier bit times
// [RULE4] No carrier after marker or without it
// [RULE5] One to sixteen frames with timed gaps
// [RULE6] Scale bit multiplies initial random by forty
// [RULE7] Expired delay starts transmission automatically
// [RULE8] Gap is base plus random plus step
// [RULE9] Zero random: base and step overlap
// [RULE10] Eight bit base, zero means none
// [RULE11] Software keeps base zero or five up
// [RULE12] Timers step on divided oscillator tick
// [RULE13] Random used only with nonzero seed
// [RULE14] Seven stage generator, never zero
// [RULE15] Generator presets to 40 hex
// [RULE16] Sample random, then step exactly once
// [RULE17] Software never loads zero seed
// [RULE18] Running random value is not readable
// [RULE19] Step time times frames sent, gaps only
// [RULE20] Repeat count plus one frames
// [RULE21] Keep-alive holds digital power in stop
// [RULE22] Software zeroes step when unused
// [RULE23] Finish clears send, stops output stage
// [RULE24] Feedback polynomial x7 plus x6 plus 1
`timescale 1ns/10ps
`default_nettype none

module rfis_sequencer #(
	parameter int TICK_CYCLES = rfis_pkg::TICK_CYCLES
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	// Register port
	input  wire logic [7:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [31:0] rdata_o,
	// Power state
	input  wire logic        lowest_stop_mode_i,
	output logic             power_hold_o,
	// Output stage
	output logic             pa_on_o,
	output logic             tx_bit_o,
	output logic             end_marker_o,
	output logic             irq_o
);
	import rfis_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// State
	typedef struct packed {
		rfis_state_e      state;
		logic             irq_en;
		logic             eom_en;
		logic             iscale;
		logic             keep;
		logic             done;
		logic [7:0]       flen;
		logic [3:0]       rep;
		logic [7:0]       base;
		logic [6:0]       seed;
		logic [5:0]       step;
		logic [7:0][31:0] buffer;
		logic [12:0]      dly;
		logic             rnd_used;
		logic             lfsr_step;
		logic             tick_restart;
		logic [11:0]      bitclk;
		logic [8:0]       bitcnt;
		logic [3:0]       frame;
		logic             pa_on;
		logic             tx_bit;
		logic             marker;
		logic             irq;
		logic             hold;
		logic [31:0]      rdata;
	} rfis_seq_s;

	rfis_seq_s r;
	rfis_seq_s next_r;
	logic      tick;
	logic [6:0] rnd_now;
	logic      seed_load;

	////////////////////////////////////////////////////////////////////////
	// Helpers

	// Little-endian buffer: bit 0 of byte 0 first
	function automatic logic buf_bit(input logic [7:0][31:0] b,
			input logic [7:0] idx);
		buf_bit = b[idx[7:5]][idx[4:0]];
	endfunction : buf_bit

	// [RULE9] [RULE10] overlap, zero base
	// Total wait in ticks; a zero random part lets base and step overlap
	function automatic logic [12:0] gap_ticks(input logic [7:0] bse,
			input logic [12:0] rnd, input logic [9:0] fnt);
		logic [12:0] b13;
		logic [12:0] f13;
		b13 = {5'h00, bse};
		f13 = {3'h0, fnt};
		if (rnd == 13'h0000) begin
			gap_ticks = (b13 > f13) ? b13 : f13;
		end else begin
			gap_ticks = b13 + rnd + f13;
		end
	endfunction : gap_ticks

	////////////////////////////////////////////////////////////////////////
	// Submodules
	rfis_tick #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_tick (
		.clk_i       (clk_i),
		.sys_rst_i   (sys_rst_i),
		.restart_i   (r.tick_restart),
		.tick_o      (tick)
	);

	// Writing the seed register also reloads the running generator
	assign seed_load = wr_i && (addr_i == OFS_SEED);

	rfis_lfsr u_lfsr (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.load_i    (seed_load),
		.seed_i    (wdata_i[6:0]),
		.step_i    (r.lfsr_step),
		.value_o   (rnd_now)
	);

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		logic [12:0] rnd_part;
		logic [9:0]  fn_part;
		logic        use_rnd;
		rnd_part = 13'h0000;
		fn_part = 10'h000;
		use_rnd = 1'b0;
		next_r = r;
		next_r.lfsr_step = 1'b0;
		next_r.tick_restart = 1'b0;
		next_r.irq = 1'b0;

		// [RULE21] digital power hold
		next_r.hold = r.keep || !lowest_stop_mode_i;

		// [RULE13] random only with seed
		use_rnd = (r.seed != 7'h00);

		// Register writes; changing fields mid-transmission is unsupported
		if (wr_i) begin
			case (addr_i)
				OFS_CTRL: begin
					next_r.irq_en = wdata_i[CTRL_IRQEN];
					next_r.eom_en = wdata_i[CTRL_EOM];
					next_r.iscale = wdata_i[CTRL_ISCALE];
					next_r.keep = wdata_i[CTRL_KEEP];
					if (wdata_i[CTRL_DONE]) begin
						next_r.done = 1'b0;
					end
				end
				OFS_FLEN: next_r.flen = wdata_i[7:0];
				OFS_REP:  next_r.rep = wdata_i[3:0];
				OFS_BASE: next_r.base = wdata_i[7:0];
				OFS_SEED: next_r.seed = wdata_i[6:0];
				OFS_STEP: next_r.step = wdata_i[5:0];
				default: begin
					if (addr_i[7:5] == OFS_BUF_PAGE) begin
						next_r.buffer[addr_i[4:2]] = wdata_i;
					end
				end
			endcase
		end

		// Register reads; the running random value has no address
		next_r.rdata = 32'h0000_0000;
		if (rd_i) begin
			case (addr_i)
				// [RULE18] status without random value
				OFS_CTRL: next_r.rdata = {26'h000_0000, r.done, r.keep,
					r.iscale, r.eom_en, r.irq_en, (r.state != ST_IDLE)};
				OFS_FLEN: next_r.rdata = {24'h00_0000, r.flen};
				OFS_REP:  next_r.rdata = {28'h000_0000, r.rep};
				OFS_BASE: next_r.rdata = {24'h00_0000, r.base};
				OFS_SEED: next_r.rdata = {25'h000_0000, r.seed};
				OFS_STEP: next_r.rdata = {26'h000_0000, r.step};
				default: begin
					if (addr_i[7:5] == OFS_BUF_PAGE) begin
						next_r.rdata = r.buffer[addr_i[4:2]];
					end
				end
			endcase
		end

		case (r.state)
			ST_IDLE: begin
				if (wr_i && addr_i == OFS_CTRL && wdata_i[CTRL_SEND]) begin
					// [RULE6] scaled initial random part
					if (use_rnd) begin
						rnd_part = wdata_i[CTRL_ISCALE] ?
							13'(rnd_now * INIT_SCALE) : {6'h00, rnd_now};
					end
					next_r.dly = gap_ticks(r.base, rnd_part, 10'h000);
					next_r.rnd_used = use_rnd;
					next_r.frame = 4'h0;
					next_r.tick_restart = 1'b1;
					next_r.state = ST_DELAY;
				end
			end
			ST_DELAY: begin
				// [RULE7] automatic start on expiry
				if (r.dly == 13'h0000) begin
					// [RULE16] step after use
					next_r.lfsr_step = r.rnd_used;
					next_r.bitclk = 12'h000;
					next_r.bitcnt = 9'h000;
					next_r.pa_on = 1'b1;
					next_r.tx_bit = buf_bit(r.buffer, 8'h00);
					next_r.state = ST_FRAME;
				// [RULE12] count on tick
				end else if (tick) begin
					next_r.dly = r.dly - 13'h0001;
				end
			end
			ST_FRAME: begin
				if (r.bitclk == BIT_LAST) begin
					next_r.bitclk = 12'h000;
					// [RULE1] frame length plus one
					if (r.bitcnt == {1'b0, r.flen}) begin
						next_r.bitcnt = 9'h000;
						// [RULE3] append carrier tail
						if (r.eom_en) begin
							next_r.tx_bit = 1'b1;
							next_r.marker = 1'b1;
							next_r.state = ST_MARKER;
						// [RULE4] no tail when disabled
						end else begin
							next_r.pa_on = 1'b0;
							next_r.tx_bit = 1'b0;
							next_r.state = ST_END;
						end
					end else begin
						next_r.bitcnt = r.bitcnt + 9'h001;
						next_r.tx_bit = buf_bit(r.buffer, 8'(r.bitcnt + 9'h001));
					end
				end else begin
					next_r.bitclk = r.bitclk + 12'h001;
				end
			end
			ST_MARKER: begin
				if (r.bitclk == BIT_LAST) begin
					next_r.bitclk = 12'h000;
					next_r.bitcnt = r.bitcnt + 9'h001;
					// [RULE4] carrier off after tail
					if (r.bitcnt == EOM_BITS - 9'h001) begin
						next_r.marker = 1'b0;
						next_r.pa_on = 1'b0;
						next_r.tx_bit = 1'b0;
						next_r.state = ST_END;
					end
				end else begin
					next_r.bitclk = r.bitclk + 12'h001;
				end
			end
			ST_END: begin
				// [RULE20] repeat count plus one
				if (r.frame == r.rep) begin
					// [RULE23] finish clears send
					next_r.state = ST_IDLE;
					next_r.done = 1'b1;
					// [RULE2] interrupt when enabled
					next_r.irq = r.irq_en;
				end else begin
					// [RULE19] step times frames sent
					fn_part = 10'(r.step * ({1'b0, r.frame} + 5'h01));
					if (use_rnd) begin
						rnd_part = {6'h00, rnd_now};
					end
					// [RULE8] interframe sum
					next_r.dly = gap_ticks(r.base, rnd_part, fn_part);
					next_r.rnd_used = use_rnd;
					next_r.frame = r.frame + 4'h1;
					next_r.tick_restart = 1'b1;
					// [RULE5] timed gap between frames
					next_r.state = ST_DELAY;
				end
			end
			default: begin
				next_r.state = ST_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			r <= '0;
			r.flen <= RST_FLEN;
			r.rep <= RST_REP;
			r.base <= RST_BASE;
			r.seed <= RST_SEED;
			r.step <= RST_STEP;
			r.state <= ST_IDLE;
		end else begin
			r <= next_r;
		end
	end

	assign rdata_o = r.rdata;
	assign power_hold_o = r.hold;
	assign pa_on_o = r.pa_on;
	assign tx_bit_o = r.tx_bit;
	assign end_marker_o = r.marker;
	assign irq_o = r.irq;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	sequence s_last_bit;
		r.state == ST_FRAME && r.bitclk == BIT_LAST;
	endsequence

	sequence s_frame_close;
		s_last_bit ##0 (r.bitcnt == {1'b0, r.flen});
	endsequence

	sequence s_tail_close;
		r.state == ST_MARKER && r.bitclk == BIT_LAST
			&& r.bitcnt == EOM_BITS - 9'h001;
	endsequence

	// [RULE1] frame ends at length
	a_frame_length: assert property (s_last_bit ##1 (r.state != ST_FRAME)
		|-> $past(r.bitcnt) == {1'b0, r.flen}) // [RULE1]
		else $error("frame ended at wrong bit count");

	// [RULE2] interrupt needs enable
	a_irq_enable: assert property (irq_o |-> r.irq_en && r.done) // [RULE2]
		else $error("interrupt raised while disabled");

	// [RULE3] tail follows frame
	a_marker_start: assert property (s_frame_close ##0 r.eom_en // [RULE3]
		|=> end_marker_o && pa_on_o && tx_bit_o)
		else $error("end marker did not start");

	// [RULE4] carrier off after tail
	a_tail_off: assert property (s_tail_close |=> !pa_on_o // [RULE4]
		##1 !pa_on_o) else $error("carrier stayed on after marker");

	// [RULE4] no tail when disabled
	a_no_tail: assert property (s_frame_close ##0 !r.eom_en // [RULE4]
		|=> !end_marker_o && !pa_on_o) else $error("unexpected marker");

	// [RULE20] frame count bounded
	a_frame_bound: assert property (r.state != ST_IDLE // [RULE20]
		|-> r.frame <= r.rep) else $error("too many frames");

	// [RULE16] single step per interval
	a_step_once: assert property (r.lfsr_step |=> !r.lfsr_step // [RULE16]
		##1 !r.lfsr_step) else $error("random generator stepped twice");

	// [RULE21] power hold in stop
	a_keep_alive: assert property (r.keep |=> power_hold_o) // [RULE21]
		else $error("digital power dropped with keep-alive set");

	// [RULE23] finish turns stage off
	a_finish_off: assert property ($rose(r.done) |-> !pa_on_o // [RULE23]
		&& r.state == ST_IDLE) else $error("finish left output stage on");

	// [RULE7] expiry starts frame
	a_auto_start: assert property (r.state == ST_DELAY // [RULE7]
		&& r.dly == 13'h0000 |=> pa_on_o && r.state == ST_FRAME)
		else $error("expired delay did not start a frame");

endmodule : rfis_sequencer

`default_nettype wire

// file: rfis_sequencer_test.sv
// Self-checking testbench for the frame interval sequencer
`timescale 1ns/10ps
`default_nettype none

module rfis_sequencer_test;
	import rfis_pkg::*;
	localparam int TICK = 10;
	logic         clk_i = 1'b0;
	logic         sys_rst_i = 1'b1;
	logic [7:0]   addr_i = 8'h00;
	logic [31:0]  wdata_i = 32'h00000000;
	logic         wr_i = 1'b0;
	logic         rd_i = 1'b0;
	logic         stop_i = 1'b0;
	logic         start = 1'b0;
	logic [31:0]  rdata_o;
	logic         power_hold_o, pa_on_o, tx_bit_o, end_marker_o, irq_o;
	logic [4:0]   frames;
	logic [255:0] bits, buffer;
	logic [8:0]   nbits;
	logic [15:0]  on_cyc, mark_cyc, errs;
	logic [15:0]  gaps [16];
	logic [3:0]   irqs;
	logic [31:0]  d, v;
	int           bad_count = 0;
	int           samples_checked = 0;
	int           seed = 32'hf9c7;
	logic [7:0]   ofs [6] = '{OFS_CTRL, OFS_FLEN, OFS_REP, OFS_BASE,
		OFS_SEED, OFS_STEP};
	logic [7:0]   rst [6] = '{8'h00, RST_FLEN, 8'h00, RST_BASE, 8'h00, 8'h00};

	always #10 clk_i = ~clk_i;

	rfis_sequencer #(.TICK_CYCLES(TICK)) u_rfis_sequencer (.clk_i(clk_i),
		.sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.lowest_stop_mode_i(stop_i), .power_hold_o(power_hold_o),
		.pa_on_o(pa_on_o), .tx_bit_o(tx_bit_o),
		.end_marker_o(end_marker_o), .irq_o(irq_o));
	rfis_rf_model u_rfis_rf_model (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.start_i(start), .pa_on_i(pa_on_o), .tx_bit_i(tx_bit_o),
		.end_marker_i(end_marker_o), .irq_i(irq_o), .frames_o(frames),
		.bits_o(bits), .nbits_o(nbits), .on_cyc_o(on_cyc),
		.mark_cyc_o(mark_cyc), .errs_o(errs), .irqs_o(irqs), .gaps_o(gaps));

	////////////////////////////////////////////////////////////////////////
	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : finish_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Tick divider may restart late, so a gap may run up to 14 cycles over its nominal length
	task automatic chk_rng(input logic [31:0] got, input int lo, input int hi);
		samples_checked++;
		if ($isunknown(got) || got < lo || got > hi) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, lo);
		end
	endtask : chk_rng

	task automatic wr(input logic [7:0] a, input logic [31:0] v,
		input logic s);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'b1;
		start <= s;
		@(posedge clk_i);
		wr_i <= 1'b0;
		start <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		@(negedge clk_i);
		v = rdata_o;
	endtask : rd

	task automatic wait_idle();
		logic [31:0] v;
		int          n;
		n = 0;
		do begin
			repeat (100) @(posedge clk_i);
			rd(OFS_CTRL, v);
			n++;
		end while (v[0] !== 1'b0 && n < 500);
		if (n >= 500) begin
			bad_count++;
			finish_test();
		end
	endtask : wait_idle

	function automatic logic [6:0] nxt(input logic [6:0] s);
		return {1'b0, s[6:1]} ^ (s[0] ? LFSR_TAPS : 7'h00);
	endfunction : nxt

	////////////////////////////////////////////////////////////////////////
	// cb: bit0 irq enable, bit1 end marker, bit2 scale, bit3 keep-alive
	task automatic run(input logic [7:0] fl, input logic [3:0] rp,
		input logic [7:0] bs, input logic [6:0] sd, input logic [5:0] sp,
		input logic [3:0] cb, input logic dup);
		logic [6:0] r;
		int         g;
		for (int k = 0; k < 8; k++) begin
			buffer[k*32 +: 32] = $random(seed);
			wr(8'h20 + 8'(4 * k), buffer[k*32 +: 32], 1'b0);
		end
		wr(OFS_FLEN, 32'(fl), 1'b0);
		wr(OFS_REP, 32'(rp), 1'b0);
		wr(OFS_BASE, 32'(bs), 1'b0);
		wr(OFS_SEED, 32'(sd), 1'b0);
		wr(OFS_STEP, 32'(sp), 1'b0);
		wr(OFS_CTRL, {27'h0, cb, 1'b1}, 1'b1);
		// Second send while busy must not restart the sequence
		if (dup)
			wr(OFS_CTRL, {27'h0, cb, 1'b1}, 1'b0);
		wait_idle();
		chk(32'(frames), 32'(rp) + 32'h1);
		chk(32'(nbits), 32'(fl) + 32'h1);
		g = (1 << (fl + 1)) - 1;
		chk(bits[31:0] & 32'(g), buffer[31:0] & 32'(g));
		chk(32'(on_cyc), (32'(fl) + 1 + (cb[1] ? 2 : 0)) * 2500);
		chk(32'(mark_cyc), cb[1] ? 5000 : 0);
		chk(32'(errs), 32'h0);
		chk(32'(irqs), 32'(cb[0]));
		rd(OFS_CTRL, d);
		chk(d, {26'h0, 1'b1, cb, 1'b0});
		wr(OFS_CTRL, {26'h0, 1'b1, cb, 1'b0}, 1'b0);
		rd(OFS_CTRL, d);
		chk(d, {27'h0, cb, 1'b0});
		rd(OFS_SEED, d);
		chk(d, 32'(sd));
		r = sd;
		for (int k = 0; k <= rp; k++) begin
			if (k > 0 && sd != 7'h00)
				r = nxt(r);
			if (sd != 7'h00)
				g = bs + r * ((k == 0 && cb[2]) ? 40 : 1) + (k > 0 ? sp * k : 0);
			else
				g = (k == 0 || bs > sp * k) ? int'(bs) : sp * k;
			chk_rng(32'(gaps[k]), g * TICK, g * TICK + 14);
		end
		$display("transmission test done, frames %0d", rp + 1);
	endtask : run

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			rd(ofs[i], d);
			chk(d, 32'(rst[i]));
		end
		wr(8'hFC, 32'hFFFFFFFF, 1'b0);
		rd(8'hFC, d);
		chk(d, 32'h0);
		for (int i = 0; i < 4; i++) begin
			v = $random(seed);
			wr(OFS_BASE, v, 1'b0);
			wr(OFS_STEP, v, 1'b0);
			rd(OFS_BASE, d);
			chk(d, 32'(v[7:0]));
			rd(OFS_STEP, d);
			chk(d, 32'(v[5:0]));
		end
		$display("register test done");
		for (int i = 0; i < 4; i++) begin
			wr(OFS_CTRL, {27'h0, i[0], 4'h0}, 1'b0);
			stop_i <= i[1];
			repeat (3) @(posedge clk_i);
			@(negedge clk_i);
			chk(32'(power_hold_o), 32'(i[0] | !i[1]));
		end
		stop_i <= 1'b1;
		$display("power test done");
		// Base kept at zero or five and up; seed nonzero only in the second run
		run(8'h02, 4'h0, 8'h06, 7'h00, 6'h00, 4'b0011, 1'b0);
		run(8'h01, 4'h2, 8'h05, 7'($random(seed) & 6) | 7'h01, 6'h03,
			4'b0100, 1'b1);
		run(8'(($random(seed) & 3) + 1), 4'h2, 8'h06, 7'h00, 6'h04, 4'b1001,
			1'b0);
		run(8'h01, 4'h0, 8'h00, 7'h00, 6'h00, 4'b0001, 1'b0);
		finish_test();
	end
endmodule : rfis_sequencer_test

`default_nettype wire

// file: rfis_tick.sv
// Millisecond tick divider for the interval timers
`timescale 1ns/10ps
`default_nettype none

module rfis_tick #(
	parameter int TICK_CYCLES = rfis_pkg::TICK_CYCLES
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic sys_rst_i,
	// Control
	input  wire logic restart_i,
	output logic      tick_o
);
	import rfis_pkg::*;

	typedef struct packed {
		logic [15:0] cnt;
		logic        tick;
	} rfis_tick_s;

	localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

	rfis_tick_s r;
	rfis_tick_s next_r;

	// Restart aligns the first step with the start of a delay
	always_comb begin
		next_r = r;
		next_r.tick = 1'b0;
		if (restart_i) begin
			next_r.cnt = 16'h0000;
		end else if (r.cnt == TICK_LAST) begin
			next_r.cnt = 16'h0000;
			next_r.tick = 1'b1;
		end else begin
			next_r.cnt = r.cnt + 16'h0001;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign tick_o = r.tick;

	// [RULE12] one cycle tick
	a_tick_single: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		tick_o |=> !tick_o) else $error("tick lasted more than one cycle"); // [RULE12]

endmodule : rfis_tick

`default_nettype wire
